// >>> design/ddrw_pkg.sv
// constants, types and helpers shared by both ends of the link
// assumes: imported by both ends and the bench
package ddrw_pkg;
    localparam int DQ_W      = 16;
    localparam int BG_W      = 1;
    localparam int BA_W      = 1;
    localparam int ADDR_W    = 12;
    localparam int COL_W     = 4;
    localparam int BCOL_W    = 3;
    localparam int WL_MAX    = 40;
    localparam int FRAME_CYC = 4;
    localparam int CHOP_CYC  = 2;
    localparam int AV_W      = 5;
    localparam int CWL_W     = 5;
    localparam int WR_W      = 6;
    localparam int BURST_W   = 2;

    localparam logic [2:0] CMD_DES = 3'h0;
    localparam logic [2:0] CMD_ACT = 3'h1;
    localparam logic [2:0] CMD_WR  = 3'h2;
    localparam logic [2:0] CMD_RD  = 3'h3;
    localparam logic [2:0] CMD_PRE = 3'h4;
    localparam logic [2:0] CMD_MRS = 3'h5;

    localparam logic [1:0] BURST_FIX8 = 2'h0;
    localparam logic [1:0] BURST_SEL  = 2'h1;
    localparam logic [1:0] BURST_FIX4 = 2'h2;

    localparam int MR_BURST_LSB = 0;
    localparam int MR_WR_LSB    = 4;
    localparam logic [ADDR_W-1:0] MR_RST = 12'h0C0;

    localparam logic [CWL_W-1:0] CWL_MIN    = 5'h09;
    localparam logic [3:0]       CCD_MIN    = 4'h4;
    localparam logic [3:0]       CCD_BAD_2T = 4'h5;

    localparam logic [AV_W-1:0] AV_CTRL = 5'h00;
    localparam logic [AV_W-1:0] AV_TIME = 5'h04;
    localparam logic [AV_W-1:0] AV_DATA = 5'h08;
    localparam logic [AV_W-1:0] AV_CMD  = 5'h0C;
    localparam logic [AV_W-1:0] AV_STAT = 5'h10;

    localparam int CT_BURST_LSB = 0;
    localparam int CT_PRE2      = 2;
    localparam int CT_CWL_LSB   = 3;
    localparam int CT_AL_LSB    = 8;
    localparam int TM_WR_LSB    = 0;
    localparam int TM_WTRS_LSB  = 6;
    localparam int TM_WTRL_LSB  = 12;
    localparam int TM_CCD_LSB   = 18;
    localparam int CM_OP_LSB    = 0;
    localparam int CM_A12       = 3;
    localparam int CM_AP        = 4;
    localparam int CM_BG        = 5;
    localparam int CM_BA        = 6;
    localparam int CM_ADDR_LSB  = 16;
    localparam int ST_CNT_LSB   = 0;
    localparam int ST_BUSY      = 2;
    localparam int ST_ADJ       = 3;
    localparam int ST_MODE      = 4;

    localparam logic [31:0] CTRL_RST = 32'h0000_0048;
    localparam logic [31:0] TIME_RST = 32'h0010_60CC;

    typedef enum logic [1:0] {
        S_MODE = 2'b01,
        S_RUN  = 2'b10
    } ddrw_state_type;

    function automatic logic burst_is_chop(input logic [1:0] field,
                                           input logic       a12);
        return (field == BURST_FIX4) || ((field == BURST_SEL) && !a12);
    endfunction
endpackage

// >>> design/ddrw_link_if.sv
// command, address and write-data wires between controller and memory
// assumes: both ends on one clock; two data beats per clock, low half first
`timescale 1ns/1ps
`default_nettype none
interface ddrw_link_if #(
    parameter int DQ_W   = 16,
    parameter int BG_W   = 1,
    parameter int BA_W   = 1,
    parameter int ADDR_W = 12
);
    logic [2:0]        cmd;
    logic [BG_W-1:0]   bg;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic              burst_chop_address_bit;
    logic              auto_pre;
    logic [2*DQ_W-1:0] dq;
    logic              dq_valid;

    modport ctrl (output cmd, bg, ba, addr, burst_chop_address_bit,
                  auto_pre, dq, dq_valid);
    modport mem  (input cmd, bg, ba, addr, burst_chop_address_bit,
                  auto_pre, dq, dq_valid);
endinterface
`default_nettype wire

// >>> design/ddrw_mem.sv
// memory end: takes commands, stores write bursts, closes banks after
// automatic precharge. assumes: controller keeps spacing and latency
`timescale 1ns/1ps
`default_nettype none
module ddrw_mem #(
    parameter int DQ_W   = ddrw_pkg::DQ_W,
    parameter int BG_W   = ddrw_pkg::BG_W,
    parameter int BA_W   = ddrw_pkg::BA_W,
    parameter int ADDR_W = ddrw_pkg::ADDR_W,
    parameter int COL_W  = ddrw_pkg::COL_W,
    parameter int QD     = 4,
    parameter int MA_W   = BG_W + BA_W + COL_W,
    parameter int NB     = 2 ** (BG_W + BA_W)
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    ddrw_link_if.mem             link,
    input  wire logic [MA_W-1:0] rd_addr,
    output logic      [DQ_W-1:0] rd_data,
    output logic      [NB-1:0]   bank_open,
    output logic      [1:0]      burst_mode
);
    import ddrw_pkg::*;
    localparam int BK_W = BG_W + BA_W;
    localparam int EW   = 2 + BK_W + COL_W;
    localparam int QP_W = $clog2(QD);
    localparam int FC_W = $clog2(FRAME_CYC);
    localparam int MW   = 2 ** MA_W;

    logic [ADDR_W-1:0] mode_r, mode_nxt;
    logic [NB-1:0]     open_r, open_nxt;
    logic [EW-1:0]     q_r [QD];
    logic [EW-1:0]     q_nxt [QD];
    logic [QP_W-1:0]   wp_r, wp_nxt, rp_r, rp_nxt;
    logic [QP_W:0]     qc_r, qc_nxt;
    logic              fr_r, fr_nxt;
    logic [FC_W-1:0]   fc_r, fc_nxt;
    logic [EW-1:0]     cur_r, cur_nxt;
    logic [DQ_W-1:0]   mem_r [MW];
    logic [DQ_W-1:0]   mem_nxt [MW];
    logic [DQ_W-1:0]   rd_r, rd_nxt;
    logic [NB-1:0]     ap_go, ap_done;
    logic [EW-1:0]     ent;
    logic [FC_W-1:0]   k;
    logic              push, start, last;

    function automatic logic [MA_W-1:0] beat_addr(input logic [EW-1:0] e,
                                                  input logic [FC_W-1:0] kk,
                                                  input logic b);
        logic [BCOL_W-1:0] lo;
        lo = e[BCOL_W-1:0] + BCOL_W'({kk, b});
        return {e[BK_W+COL_W-1:BCOL_W], lo};
    endfunction

    always_comb begin
        mode_nxt = mode_r;
        open_nxt = open_r;
        q_nxt    = q_r;
        wp_nxt   = wp_r;
        rp_nxt   = rp_r;
        fr_nxt   = fr_r;
        fc_nxt   = fc_r;
        cur_nxt  = cur_r;
        mem_nxt  = mem_r;
        ap_go    = '0;
        last     = 1'b0;
        push     = 1'b0;
        start    = !fr_r && link.dq_valid && (qc_r != '0);
        ent      = fr_r ? cur_r : q_r[rp_r];
        k        = fr_r ? fc_r : '0;
        case (link.cmd)
            CMD_MRS: mode_nxt = link.addr;
            CMD_ACT: open_nxt[{link.bg, link.ba}] = 1'b1;
            CMD_PRE: open_nxt[{link.bg, link.ba}] = 1'b0;
            CMD_WR: begin
                push = qc_r != (QP_W+1)'(QD);
                if (push) begin
                    q_nxt[wp_r] = {burst_is_chop(
                                       mode_r[MR_BURST_LSB +: BURST_W],
                                       link.burst_chop_address_bit),
                                   link.auto_pre, link.bg, link.ba,
                                   link.addr[COL_W-1:0]};
                    wp_nxt = wp_r + 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (fr_r || start) begin
            if (link.dq_valid && (!ent[EW-1] || k < FC_W'(CHOP_CYC))) begin
                for (int b = 0; b < 2; b++) begin
                    mem_nxt[beat_addr(ent, k, 1'(b))] =
                        link.dq[b*DQ_W +: DQ_W];
                end
            end
            if (start) begin
                cur_nxt = ent;
                rp_nxt  = rp_r + 1'b1;
            end
            // frame ends at its fourth cycle, even when chopped
            last   = k == FC_W'(FRAME_CYC - 1);
            fr_nxt = !last;
            fc_nxt = last ? '0 : k + 1'b1;
            if (last && ent[EW-2]) begin
                ap_go[ent[BK_W+COL_W-1:COL_W]] = 1'b1;
            end
        end
        qc_nxt = qc_r + (QP_W+1)'(push) - (QP_W+1)'(start);
        open_nxt = open_nxt & ~ap_done;
        rd_nxt = mem_r[rd_addr];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= MR_RST;
            open_r <= '0;
            wp_r   <= '0;
            rp_r   <= '0;
            qc_r   <= '0;
            fr_r   <= 1'b0;
            fc_r   <= '0;
            cur_r  <= '0;
            rd_r   <= '0;
            q_r    <= '{default: '0};
            mem_r  <= '{default: '0};
        end else begin
            mode_r <= mode_nxt;
            open_r <= open_nxt;
            wp_r   <= wp_nxt;
            rp_r   <= rp_nxt;
            qc_r   <= qc_nxt;
            fr_r   <= fr_nxt;
            fc_r   <= fc_nxt;
            cur_r  <= cur_nxt;
            rd_r   <= rd_nxt;
            q_r    <= q_nxt;
            mem_r  <= mem_nxt;
        end
    end

    // one recovery timer per bank so overlapping precharges stay apart
    for (genvar g = 0; g < NB; g++) begin : g_ap
        logic [WR_W-1:0] t_r, t_nxt;
        always_comb begin
            t_nxt = t_r;
            if (ap_go[g]) begin
                t_nxt = mode_r[MR_WR_LSB +: WR_W];
            end else if (t_r != '0) begin
                t_nxt = t_r - 1'b1;
            end
        end
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                t_r <= '0;
            end else begin
                t_r <= t_nxt;
            end
        end
        assign ap_done[g] = t_r == WR_W'(1);
    end

    assign rd_data    = rd_r;
    assign bank_open  = open_r;
    assign burst_mode = mode_r[MR_BURST_LSB +: BURST_W];
endmodule
`default_nettype wire

// >>> design/ddrw_ctrl.sv
// controller end: Avalon-MM register slave, two-entry command buffer,
// write data scheduler and write turnaround spacing.
// assumes: software activates banks before writing them
//
// Summary of operation
// - field 00, or 01 with bit high: eight
// - field 01 with bit low: chopped write
// - field 10: every access chopped
// - length may change on every write
// - two-cycle preamble: latency above the minimum
// - recovery counted from edge after last beat
// - precharge waits write recovery after burst
// - other-group read waits short interval
// - same-group read waits long interval
// - auto precharge after recovery count
// - idle cycles carry deselect
// - two-cycle preamble forbids spacing of five
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ddrw_ctrl #(
    parameter int DQ_W   = ddrw_pkg::DQ_W,
    parameter int BG_W   = ddrw_pkg::BG_W,
    parameter int BA_W   = ddrw_pkg::BA_W,
    parameter int ADDR_W = ddrw_pkg::ADDR_W,
    parameter int WL_MAX = ddrw_pkg::WL_MAX
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic [ddrw_pkg::AV_W-1:0] avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    ddrw_link_if.ctrl                     link
);
    import ddrw_pkg::*;
    localparam int BK_W = BG_W + BA_W;
    localparam int WIN  = WL_MAX + FRAME_CYC;

    ddrw_state_type    st_r, st_nxt;
    logic [31:0]       ctrl_r, ctrl_nxt, time_r, time_nxt;
    logic [DQ_W-1:0]   seed_r, seed_nxt;
    logic [31:0]       bq_r [2];
    logic [31:0]       bq_nxt [2];
    logic [1:0]        bc_r, bc_nxt;
    logic              wq_r, wq_nxt;
    logic [31:0]       rdat_r, rdat_nxt;
    logic [2:0]        cmd_r, cmd_nxt;
    logic [BG_W-1:0]   bg_r, bg_nxt;
    logic [BA_W-1:0]   ba_r, ba_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic              a12_r, a12_nxt, ap_r, ap_nxt;
    logic              sv_r [WIN];
    logic              sv_nxt [WIN];
    logic [2*DQ_W-1:0] sd_r [WIN];
    logic [2*DQ_W-1:0] sd_nxt [WIN];
    logic [6:0]        wend_r, wend_nxt;
    logic [5:0]        post_r, post_nxt;
    logic [3:0]        sp_r, sp_nxt;
    logic [BK_W-1:0]   lbk_r, lbk_nxt;

    logic [1:0]        burst;
    logic              pre2, adj, hchop, go, issue, push, pop;
    logic [CWL_W-1:0]  write_column_latency, al, cwl_e;
    logic [6:0]        wl, wl_sum, nc;
    logic [WR_W-1:0]   wr, wtr;
    logic [3:0]        ccd;
    logic [31:0]       h, stat;
    logic [2:0]        hop;
    logic [BK_W-1:0]   hbk;
    logic [ADDR_W-1:0] mr;

    always_comb begin
        burst = ctrl_r[CT_BURST_LSB +: BURST_W];
        pre2  = ctrl_r[CT_PRE2];
        write_column_latency   = ctrl_r[CT_CWL_LSB +: CWL_W];
        al    = ctrl_r[CT_AL_LSB +: CWL_W];
        adj    = pre2 && (write_column_latency <= CWL_MIN);
        cwl_e  = adj ? CWL_MIN + 5'h01 : write_column_latency;
        wl_sum = 7'(cwl_e) + 7'(al);
        // beyond the window the data slots would not fit
        wl     = (int'(wl_sum) > WL_MAX) ? 7'(WL_MAX) : wl_sum;
        wr     = time_r[TM_WR_LSB +: WR_W];
        ccd    = time_r[TM_CCD_LSB +: 4];
        ccd    = (ccd < CCD_MIN) ? CCD_MIN : ccd;
        h      = bq_r[0];
        hop    = h[CM_OP_LSB +: 3];
        hbk    = {h[CM_BG +: BG_W], h[CM_BA +: BA_W]};
        // length as the memory decodes it
        hchop  = burst_is_chop(burst, h[CM_A12]);
        nc     = hchop ? 7'(CHOP_CYC) : 7'(FRAME_CYC);
        wtr    = (hbk[BK_W-1 -: BG_W] == lbk_r[BK_W-1 -: BG_W]) ?
                 time_r[TM_WTRL_LSB +: WR_W] : time_r[TM_WTRS_LSB +: WR_W];
        go = 1'b1;
        case (hop)
            CMD_WR: begin
                // no spacing of five with two-cycle preamble
                go = (sp_r >= ccd) && !(pre2 && (sp_r == CCD_BAD_2T));
            end
            CMD_RD: begin
                go = (sp_r >= ccd) && !(pre2 && (sp_r == CCD_BAD_2T))
                     && (wend_r == '0) && (post_r >= wtr);
            end
            CMD_PRE: begin
                // precharge of written bank waits recovery
                go = (hbk != lbk_r) || ((wend_r == '0) && (post_r >= wr));
            end
            default: begin
            end
        endcase
        issue = (st_r == S_RUN) && (bc_r != 2'h0) && go;
        mr = '0;
        mr[MR_BURST_LSB +: BURST_W] = burst;
        mr[MR_WR_LSB +: WR_W]       = wr;
        stat = '0;
        stat[ST_CNT_LSB +: 2] = bc_r;
        stat[ST_BUSY]         = wend_r != '0;
        stat[ST_ADJ]          = adj;
        stat[ST_MODE]         = st_r == S_MODE;
    end

    always_comb begin
        st_nxt   = st_r;
        ctrl_nxt = ctrl_r;
        time_nxt = time_r;
        seed_nxt = seed_r;
        bq_nxt   = bq_r;
        wq_nxt   = 1'b1;
        rdat_nxt = rdat_r;
        cmd_nxt  = CMD_DES;
        bg_nxt   = bg_r;
        ba_nxt   = ba_r;
        addr_nxt = addr_r;
        a12_nxt  = a12_r;
        ap_nxt   = ap_r;
        lbk_nxt  = lbk_r;
        push     = 1'b0;
        pop      = 1'b0;
        sp_nxt   = sp_r + 4'(sp_r != 4'hF);
        wend_nxt = wend_r - 7'(wend_r != '0);
        // recovery and turnaround count from the end edge
        post_nxt = post_r + 6'(wend_r == '0 && post_r != 6'h3F);
        if (wend_r == 7'h01) begin
            post_nxt = '0;
        end
        for (int i = 0; i < WIN - 1; i++) begin
            sv_nxt[i] = sv_r[i + 1];
            sd_nxt[i] = sd_r[i + 1];
        end
        sv_nxt[WIN-1] = 1'b0;
        sd_nxt[WIN-1] = '0;
        case (st_r)
            S_MODE: begin
                // mode changes only with no write data in flight
                if (wend_r == '0) begin
                    cmd_nxt  = CMD_MRS;
                    addr_nxt = mr;
                    st_nxt   = S_RUN;
                end
            end
            S_RUN: begin
                if (issue) begin
                    pop      = 1'b1;
                    cmd_nxt  = hop;
                    bg_nxt   = h[CM_BG +: BG_W];
                    ba_nxt   = h[CM_BA +: BA_W];
                    addr_nxt = h[CM_ADDR_LSB +: ADDR_W];
                    a12_nxt  = h[CM_A12];
                    ap_nxt   = h[CM_AP];
                    if (hop == CMD_WR || hop == CMD_RD) begin
                        sp_nxt = 4'h1;
                    end
                    if (hop == CMD_WR) begin
                        // each write carries its own length
                        wend_nxt = wl + nc;
                        post_nxt = '0;
                        lbk_nxt  = hbk;
                        for (int k = 0; k < FRAME_CYC; k++) begin
                            sv_nxt[int'(wl) + k] = 7'(k) < nc;
                            sd_nxt[int'(wl) + k] =
                                {seed_r + DQ_W'(2 * k + 1),
                                 seed_r + DQ_W'(2 * k)};
                        end
                    end
                end
            end
            default: begin
                st_nxt = S_MODE;
            end
        endcase
        if (wq_r) begin
            // full buffer stalls a command write
            if (avs_read || (avs_write &&
                !(avs_address == AV_CMD && bc_r == 2'h2))) begin
                wq_nxt = 1'b0;
            end
            case (avs_address)
                AV_CTRL: rdat_nxt = ctrl_r;
                AV_TIME: rdat_nxt = time_r;
                AV_DATA: rdat_nxt = 32'(seed_r);
                AV_STAT: rdat_nxt = stat;
                default: rdat_nxt = '0;
            endcase
        end else if (avs_write) begin
            case (avs_address)
                AV_CTRL: begin
                    ctrl_nxt = avs_writedata;
                    st_nxt   = S_MODE;
                end
                AV_TIME: time_nxt = avs_writedata;
                AV_DATA: seed_nxt = avs_writedata[DQ_W-1:0];
                AV_CMD:  push = 1'b1;
                default: begin
                end
            endcase
        end
        if (pop) begin
            bq_nxt[0] = bq_r[1];
        end
        if (push) begin
            bq_nxt[bc_r[0] ^ pop] = avs_writedata;
        end
        bc_nxt = bc_r + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r   <= S_MODE;
            ctrl_r <= CTRL_RST;
            time_r <= TIME_RST;
            seed_r <= '0;
            bq_r   <= '{default: '0};
            bc_r   <= 2'h0;
            wq_r   <= 1'b1;
            rdat_r <= '0;
            cmd_r  <= CMD_DES;
            bg_r   <= '0;
            ba_r   <= '0;
            addr_r <= '0;
            a12_r  <= 1'b0;
            ap_r   <= 1'b0;
            sv_r   <= '{default: 1'b0};
            sd_r   <= '{default: '0};
            wend_r <= '0;
            post_r <= 6'h3F;
            sp_r   <= 4'hF;
            lbk_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            ctrl_r <= ctrl_nxt;
            time_r <= time_nxt;
            seed_r <= seed_nxt;
            bq_r   <= bq_nxt;
            bc_r   <= bc_nxt;
            wq_r   <= wq_nxt;
            rdat_r <= rdat_nxt;
            cmd_r  <= cmd_nxt;
            bg_r   <= bg_nxt;
            ba_r   <= ba_nxt;
            addr_r <= addr_nxt;
            a12_r  <= a12_nxt;
            ap_r   <= ap_nxt;
            sv_r   <= sv_nxt;
            sd_r   <= sd_nxt;
            wend_r <= wend_nxt;
            post_r <= post_nxt;
            sp_r   <= sp_nxt;
            lbk_r  <= lbk_nxt;
        end
    end

    assign avs_readdata                = rdat_r;
    assign avs_waitrequest             = wq_r;
    assign link.cmd                    = cmd_r;
    assign link.bg                     = bg_r;
    assign link.ba                     = ba_r;
    assign link.addr                   = addr_r;
    assign link.burst_chop_address_bit = a12_r;
    assign link.auto_pre               = ap_r;
    assign link.dq                     = sd_r[0];
    assign link.dq_valid               = sv_r[0];
endmodule
`default_nettype wire

// >>> bench/ddrw_asserts.sv
// link checker: frame timing, burst length, turnaround spacing
// assumes: WL and timing parameters match the programmed values
`timescale 1ns/1ps
`default_nettype none
module ddrw_asserts
    import ddrw_pkg::*;
#(
    parameter int WL    = 10,
    parameter int WTR_S = 3,
    parameter int WTR_L = 6,
    parameter int WR_T  = 12
) (
    input wire logic                        clk,
    input wire logic                        resetn,
    input wire logic [2:0]                  cmd,
    input wire logic [ddrw_pkg::BG_W-1:0]   bg,
    input wire logic [ddrw_pkg::BA_W-1:0]   ba,
    input wire logic [ddrw_pkg::ADDR_W-1:0] addr,
    input wire logic                        burst_chop_address_bit,
    input wire logic                        auto_pre,
    input wire logic [2*ddrw_pkg::DQ_W-1:0] dq,
    input wire logic                        dq_valid
);
    logic [1:0]           mode_r, mode_nxt;
    logic [5:0]           idle_r, idle_nxt;
    logic [BG_W+BA_W-1:0] wbank_r, wbank_nxt;
    logic                 chop;

    assign chop = (mode_r == BURST_FIX4)
                  || (mode_r == BURST_SEL && !burst_chop_address_bit);

    // idle count saturates, never wraps to zero
    always_comb begin
        mode_nxt = (cmd == CMD_MRS) ? addr[1:0] : mode_r;
        idle_nxt = dq_valid ? 6'h00 : idle_r + 6'(idle_r != 6'h3F);
        wbank_nxt = (cmd == CMD_WR) ? {bg, ba} : wbank_r;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= 2'h0;
            idle_r <= 6'h3F;
            wbank_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            idle_r <= idle_nxt;
            wbank_r <= wbank_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_write_latency: assert property (
        cmd == CMD_WR |-> ##WL dq_valid) else $error("write data misplaced");
    chk_eight_frame: assert property (
        cmd == CMD_WR && !chop |-> ##WL dq_valid [*4])
        else $error("eight-beat frame short");
    chk_chop_frame: assert property (
        cmd == CMD_WR && chop |-> ##WL dq_valid ##1 dq_valid ##1 !dq_valid
        ##1 !dq_valid) else $error("chopped frame length wrong");
    chk_beat_pairs: assert property (
        dq_valid |-> dq[2*DQ_W-1:DQ_W] == dq[DQ_W-1:0] + 1'b1)
        else $error("beat pair out of order");
    chk_column_spacing: assert property (
        cmd == CMD_WR |=> (cmd != CMD_WR && cmd != CMD_RD) [*3])
        else $error("column commands too close");
    chk_read_long: assert property (
        cmd == CMD_RD && bg == wbank_r[BA_W +: BG_W]
        |-> int'(idle_r) >= WTR_L - 1) else $error("same group read early");
    chk_read_short: assert property (
        cmd == CMD_RD |-> int'(idle_r) >= WTR_S - 1)
        else $error("read after write early");
    chk_pre_recovery: assert property (
        cmd == CMD_PRE && {bg, ba} == wbank_r |-> int'(idle_r) >= WR_T - 1)
        else $error("precharge before recovery");
endmodule
`default_nettype wire

// >>> bench/sdram_write_burst_turnaround_tb.sv
// bench: controller and memory joined by the link, driven over Avalon-MM
// assumes: queued writes share the last seed written
`timescale 1ns/1ps
`default_nettype none
module sdram_write_burst_turnaround_tb;
    import ddrw_pkg::*;
    logic              clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [AV_W-1:0]   avs_address;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [5:0]        rd_addr;
    logic [DQ_W-1:0]   rd_data;
    logic [3:0]        bank_open;
    logic [1:0]        burst_mode, mode;
    logic [DQ_W-1:0]   expm [64];
    bit                known [64];
    logic [31:0]       rd_q [$];
    logic [2*DQ_W-1:0] beat_q [$];
    logic [15:0]       s;
    int                errors = 0, n_tests = 0, cyc = 0, last_wr, gap, pw = 0;

    ddrw_link_if ddrw_link_if_inst ();
    ddrw_ctrl ddrw_ctrl_inst (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link(ddrw_link_if_inst.ctrl));
    ddrw_mem ddrw_mem_inst (.clk(clk), .resetn(resetn),
        .link(ddrw_link_if_inst.mem), .rd_addr(rd_addr), .rd_data(rd_data),
        .bank_open(bank_open), .burst_mode(burst_mode));
    ddrw_asserts ddrw_asserts_inst (.clk(clk), .resetn(resetn),
        .cmd(ddrw_link_if_inst.cmd), .bg(ddrw_link_if_inst.bg),
        .ba(ddrw_link_if_inst.ba), .addr(ddrw_link_if_inst.addr),
        .burst_chop_address_bit(ddrw_link_if_inst.burst_chop_address_bit),
        .auto_pre(ddrw_link_if_inst.auto_pre), .dq(ddrw_link_if_inst.dq),
        .dq_valid(ddrw_link_if_inst.dq_valid));

    task automatic print_verdict;
        $display("%0d mismatches in %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic av(input logic [AV_W-1:0] a, input logic [31:0] d,
                      input logic rd);
        @(posedge clk);
        if (rd) rd_q.push_back(d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic cfg(input logic [31:0] v);
        mode = v[1:0];
        av(AV_CTRL, v, 1'b0);
    endtask

    // loc is {bank group, bank, column}
    task automatic issue(input logic [2:0] op, input logic a12,
                         input logic ap, input logic [5:0] loc);
        int n;
        if (op == CMD_WR && pw == 0) s = 16'($urandom);
        n = (op != CMD_WR) ? 0 : (mode == BURST_FIX4
            || (mode == BURST_SEL && !a12)) ? 4 : 8;
        for (int j = 0; j < n; j++) begin
            expm[{loc[5:3], 3'(loc[2:0] + j)}] = s + 16'(j);
            known[{loc[5:3], 3'(loc[2:0] + j)}] = 1'b1;
        end
        for (int k = 0; k < n; k += 2)
            beat_q.push_back({s + 16'(k + 1), s + 16'(k)});
        if (op == CMD_WR && pw == 0) av(AV_DATA, {16'h0, s}, 1'b0);
        av(AV_CMD, {12'h0, loc[3:0], 9'h0, loc[4], loc[5], ap, a12, op}, 1'b0);
        if (op == CMD_WR) pw++;
    endtask

    task automatic drain;
        for (int i = 0; i < 200 && beat_q.size() != 0; i++) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            cmp(avs_readdata, rd_q.pop_front());
        if (ddrw_link_if_inst.dq_valid === 1'b1)
            cmp(ddrw_link_if_inst.dq, beat_q.pop_front());
        if (ddrw_link_if_inst.cmd === CMD_WR) begin
            gap = cyc - last_wr;
            last_wr = cyc;
            pw--;
        end
        if (cyc == 20000) begin
            errors++;
            print_verdict;
        end
    end

    initial begin
        {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {rd_addr, mode} = '0;
        void'($urandom(32'h525891A1));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        av(AV_CTRL, CTRL_RST, 1'b1);
        av(AV_TIME, TIME_RST, 1'b1);
        av(5'h14, 32'hFFFF_FFFF, 1'b0);
        av(5'h14, 32'h0, 1'b1);
        for (int b = 0; b < 4; b++) issue(CMD_ACT, 1'b0, 1'b0, {2'(b), 4'h0});
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            cfg(32'h50 | m);
            for (int a = 0; a < 2; a++) issue(CMD_WR, a[0], 1'b0, 6'($urandom));
            drain;
            cmp(burst_mode, m[1:0]);
        end
        $display("test burst modes done");
        av(AV_TIME, 32'h0014_60CC, 1'b0);
        for (int p = 0; p < 2; p++) begin
            cfg(p ? 32'h4C : 32'h50);
            issue(CMD_WR, 1'b1, 1'b0, 6'h00);
            issue(CMD_RD, 1'b1, 1'b0, {p[0], 5'h00});
            issue(CMD_WR, 1'b1, 1'b0, 6'h28);
            issue(CMD_WR, 1'b1, 1'b0, 6'h08);
            issue(CMD_PRE, 1'b0, 1'b0, 6'h08);
            issue(CMD_ACT, 1'b0, 1'b0, 6'h00);
            drain;
            cmp(gap, p ? 6 : 5);
        end
        $display("test turnaround done");
        issue(CMD_WR, 1'b0, 1'b1, 6'h30);
        for (int i = 0; i < 100 && ddrw_link_if_inst.dq_valid !== 1'b1; i++)
            @(posedge clk);
        repeat (15) @(posedge clk);
        cmp(bank_open[3], 1'b1);
        @(posedge clk);
        cmp(bank_open[3], 1'b0);
        drain;
        for (int i = 0; i < 64; i++) if (known[i]) begin
            rd_addr <= 6'(i);
            repeat (2) @(posedge clk);
            cmp(rd_data, expm[i]);
        end
        $display("test stored data done");
        print_verdict;
    end
endmodule
`default_nettype wire
